// ==== bench/bio_pin_env.sv ====
// pin-side circuitry model: outside drivers, pull-ups and floating pins
`timescale 1ns/1ns
module bio_pin_env
(
  ext,
  extEn,
  pinOut,
  pinOe,
  pullupOn,
  pinIn
);
  input wire [5:0] ext;
  input wire [5:0] extEn;
  input wire [5:0] pinOut;
  input wire [5:0] pinOe;
  input wire [5:0] pullupOn;
  output wire [5:0] pinIn;
  // outside driver wins a fight and holds its level until changed by the bench
  // a loose pin floats to the inverse of its latch so a stale value never reads as a match
  assign pinIn = (extEn & ext) | (~extEn & ((pinOe & pinOut) | (~pinOe & (pullupOn | ~pinOut))));
endmodule

// ==== bench/bio_port_top_props.sv ====
// concurrent checks on the io port pair's ports
`timescale 1ns/1ns
module bio_port_top_props
(
  input wire clk,
  input wire arst_n,
  input wire [4:0] fileAddr,
  input wire fileWe,
  input wire [7:0] fileWdata,
  input wire bitOpEn,
  input wire dirLoad,
  input wire [2:0] dirSel,
  input wire [7:0] workReg,
  input wire optionWe,
  input wire [7:0] optionWdata,
  input wire masterClearCfg,
  input wire [5:0] altFuncFirst,
  input wire sleeping,
  input wire resetCauseValid,
  input wire resetCauseWake,
  input wire [5:0] firstPinIn,
  input wire [7:0] fileRdata,
  input wire [5:0] firstPinOut,
  input wire [5:0] firstPinOe,
  input wire [5:0] secondPinOe,
  input wire [5:0] pullupOn,
  input wire wakeEvent,
  input wire pinWakeFlag
);
  reg [7:0] optShadow_q;
  // ********************
  // option shadow
  // ********************
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
      optShadow_q <= 8'hff;
    else if (optionWe)
      optShadow_q <= optionWdata;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  rst_inputs_a: assert property ($rose(arst_n) |-> firstPinOe == 6'h00 && secondPinOe == 6'h00)
    else $error("pins not inputs after reset");
  read_pins_a: assert property (fileAddr == 5'h06 |=>
    fileRdata == {2'b00, $past(firstPinIn) & ~$past(altFuncFirst)})
    else $error("port read not pin levels");
  in_only_a: assert property (!firstPinOe[3])
    else $error("input-only pin driven");
  dir_load_a: assert property (dirLoad && dirSel == 3'h6 ##1 !dirLoad |-> ##1 (firstPinOe & 6'h33) == (~$past(workReg[5:0], 2) & 6'h33))
    else $error("direction load wrong");
  latch_write_a: assert property (fileWe && fileAddr == 5'h06 ##1 !fileWe && !bitOpEn |-> ##1 firstPinOut == $past(fileWdata[5:0], 2))
    else $error("latch write lost");
  latch_hold_a: assert property (!fileWe && !bitOpEn ##2 1'b1 |-> $stable(firstPinOut))
    else $error("latch changed without write");
  timer_pin_a: assert property ($past(optShadow_q[5]) |-> !firstPinOe[2])
    else $error("timer pin driven");
  pull_group_a: assert property ($past(arst_n) |-> pullupOn == ($past(optShadow_q[6]) ? {2'b00, $past(masterClearCfg), 3'b000} : 6'h1b))
    else $error("pull-up enables wrong");
  wake_gate_a: assert property (wakeEvent |-> $past(sleeping) && !$past(optShadow_q[7]))
    else $error("wake while not allowed");
  wake_flag_a: assert property (resetCauseValid |=> pinWakeFlag == $past(resetCauseWake))
    else $error("wake flag wrong");
endmodule
bind bio_port_top bio_port_top_props bio_port_top_props_i (.*);

// ==== bench/bio_port_top_tb.sv ====
// self-checking bench for the io port pair
`timescale 1ns/1ns
module bio_port_top_tb;
  reg clk = 0, arst_n = 0, fileWe = 0, fileRe = 0, bitOpEn = 0, bitOpSet = 0, dirLoad = 0, optionWe = 0, sleeping = 0;
  reg masterClearCfg = 0, resetCauseValid = 0, resetCauseWake = 0;
  reg [4:0] fileAddr = 5'h00;
  reg [7:0] fileWdata = 8'h00, workReg = 8'h00, optionWdata = 8'h00;
  reg [2:0] bitOpIdx = 3'h0, dirSel = 3'h0;
  reg [5:0] altFuncFirst = 6'h00, altFuncSecond = 6'h00, extA = 6'h15, extB = 6'h3f, drvA = 6'h3f, drvB = 6'h3f;
  wire [7:0] fileRdata;
  wire [5:0] firstPinIn, secondPinIn, firstPinOut, firstPinOe, secondPinOut, secondPinOe, pullupOn;
  wire wakeEvent, pinWakeFlag;
  integer miscompares = 0, checked = 0;
  always #5 clk = ~clk;
  bio_port_top bio_port_top_i (.*);
  bio_pin_env envFirst_i (.ext(extA), .extEn(drvA), .pinOut(firstPinOut), .pinOe(firstPinOe), .pullupOn(pullupOn),
    .pinIn(firstPinIn));
  bio_pin_env envSecond_i (.ext(extB), .extEn(drvB), .pinOut(secondPinOut), .pinOe(secondPinOe), .pullupOn(6'h00),
    .pinIn(secondPinIn));
  task chk(input [7:0] s, input [7:0] e);
  begin
    checked = checked + 1;
    if (s !== e)
    begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input [4:0] a, input [7:0] d);
  begin
    fileAddr = a;
    fileWdata = d;
    fileWe = 1;
    @(negedge clk) fileWe = 0;
  end
  endtask
  task dirl(input [2:0] s, input [7:0] d);
  begin
    dirSel = s;
    workReg = d;
    dirLoad = 1;
    @(negedge clk) dirLoad = 0;
  end
  endtask
  task opt(input [7:0] d);
  begin
    optionWdata = d;
    optionWe = 1;
    @(negedge clk) optionWe = 0;
  end
  endtask
  task results;
  begin
    if (miscompares == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task t_drive;
  begin
    chk(firstPinOe, 8'h00);
    opt(8'hdf);
    dirl(3'h6, 8'h00);
    wr(5'h06, 8'hea);
    tick(2);
    chk(firstPinOut, 8'h2a);
    chk(firstPinOe, 8'h37);
    chk(fileRdata, 8'h15);
    drvA = 6'h00;
    tick(2);
    chk(fileRdata, 8'h22);
    opt(8'hff);
    tick(2);
    chk(firstPinOe, 8'h33);
  end
  endtask
  task t_second;
  begin
    dirl(3'h7, 8'h0c);
    wr(5'h07, 8'hff);
    altFuncSecond = 6'h21;
    tick(2);
    chk(secondPinOut, 8'h3f);
    chk(secondPinOe, 8'h33);
    chk(fileRdata, 8'h1e);
  end
  endtask
  task t_bitop;
  begin
    drvA = 6'h3f;
    extA = 6'h01;
    fileAddr = 5'h06;
    bitOpSet = 1;
    bitOpIdx = 3'h5;
    bitOpEn = 1;
    @(negedge clk) bitOpIdx = 3'h4;
    @(negedge clk) bitOpEn = 0;
    tick(2);
    chk(firstPinOut, 8'h11);
    tick(6);
    chk(firstPinOut, 8'h11);
    fileAddr = 5'h07;
    bitOpSet = 0;
    bitOpIdx = 3'h1;
    bitOpEn = 1;
    @(negedge clk) bitOpEn = 0;
    tick(2);
    chk(secondPinOut, 8'h1c);
  end
  endtask
  task t_pull_wake;
  begin
    opt(8'h9f);
    tick(2);
    chk(pullupOn, 8'h1b);
    masterClearCfg = 1;
    opt(8'h5f);
    tick(2);
    chk(pullupOn, 8'h08);
    extA = 6'h00;
    fileAddr = 5'h06;
    fileRe = 1;
    tick(1);
    fileRe = 0;
    sleeping = 1;
    extA = 6'h0c;
    tick(3);
    chk(wakeEvent, 8'h00);
    extA = 6'h1c;
    tick(2);
    chk(wakeEvent, 8'h01);
    sleeping = 0;
  end
  endtask
  task t_flag;
  begin
    fileAddr = 5'h03;
    resetCauseWake = 1;
    resetCauseValid = 1;
    tick(1);
    resetCauseValid = 0;
    tick(1);
    chk(pinWakeFlag, 8'h01);
    chk(fileRdata, 8'h80);
    resetCauseWake = 0;
    resetCauseValid = 1;
    tick(1);
    resetCauseValid = 0;
    tick(1);
    chk(pinWakeFlag, 8'h00);
    chk(fileRdata, 8'h00);
  end
  endtask
  task t_reset;
  begin
    arst_n = 0;
    tick(2);
    chk(firstPinOe, 8'h00);
    arst_n = 1;
    tick(1);
    chk(firstPinOe, 8'h00);
    chk(secondPinOe, 8'h00);
  end
  endtask
  initial
  begin
    tick(16);
    arst_n = 1;
    tick(1);
    t_drive;
    t_second;
    t_bitop;
    t_pull_wake;
    t_flag;
    t_reset;
    results;
  end
  // tests take about 63 cycles; a hang is cut off well after that
  initial
  begin
    #5000;
    miscompares = miscompares + 1;
    results;
  end
endmodule

// ==== logic/bio_port_bank.v ====
// one six-bit port: latch, write-only direction, pin read path
`timescale 1ns/1ns
`include "bio_port_defines.vh"
module bio_port_bank
(
  clk,
  arst_n,
  latchWe,
  latchWdata,
  dirWe,
  dirWdata,
  forceInMask,
  altFuncMask,
  pinIn,
  readData,
  pinOut,
  pinOe
);
  input wire clk;
  input wire arst_n;
  input wire latchWe;
  input wire [5:0] latchWdata;
  input wire dirWe;
  input wire [5:0] dirWdata;
  input wire [5:0] forceInMask;
  input wire [5:0] altFuncMask;
  input wire [5:0] pinIn;
  output wire [7:0] readData;
  output reg [5:0] pinOut;
  output reg [5:0] pinOe;

  reg [5:0] latch_q;
  reg [5:0] dir_q;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      latch_q <= `BIO_LATCH_RST;
      dir_q <= `BIO_DIR_RST; // [RL2]
    end
    else
    begin
      if (latchWe)
        latch_q <= latchWdata; // [RL16] [RL14]
      if (dirWe)
        dir_q <= dirWdata; // [RL9] [RL15]
    end
  end

  // drivers registered so the pads see clean flop outputs
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinOut <= `BIO_PINS_RST;
      pinOe <= `BIO_PINS_RST;
    end
    else
    begin
      pinOut <= latch_q;
      pinOe <= ~dir_q & ~forceInMask; // [RL10]
    end
  end

  // pins, never the latch; direction has no read path at all
  assign readData = {2'b00, pinIn & ~altFuncMask}; // [RL1] [RL3] [RL5] [RL8] [RL12]
endmodule

// ==== logic/bio_port_defines.vh ====
// constants for the bidirectional io port block
`ifndef BIO_PORT_DEFINES_VH
`define BIO_PORT_DEFINES_VH
// file register addresses
`define BIO_ADDR_STATUS 5'h03
`define BIO_ADDR_FIRST 5'h06
`define BIO_ADDR_SECOND 5'h07
// direction-load selectors
`define BIO_DIR_SEL_FIRST 3'h6
`define BIO_DIR_SEL_SECOND 3'h7
// field positions
`define BIO_PIN_W 6
`define BIO_INONLY_BIT 3
`define BIO_TMRCLK_BIT 2
`define BIO_OPT_WAKE_N_BIT 7
`define BIO_OPT_PULLUP_N_BIT 6
`define BIO_OPT_TMRSRC_BIT 5
`define BIO_STATUS_WAKE_BIT 7
// reset values
`define BIO_DIR_RST 6'h3f
`define BIO_LATCH_RST 6'h00
`define BIO_OPT_RST 8'hff
`define BIO_PINS_RST 6'h00
`define BIO_RDATA_RST 8'h00
`define BIO_FLAG_RST 1'b0
// group mask for pull-up and wake pins: bits 0,1,3,4
`define BIO_GROUP_MASK 6'h1b
`endif

// ==== logic/bio_port_top.v ====
// io port pair with pull-up, wake-on-change and status wake flag
`timescale 1ns/1ns
`include "bio_port_defines.vh"
// Overview of operation
// RL1 - port reads return the pin levels, never the output latches
// RL2 - any reset sets all direction bits, making every pin an input
// RL3 - first port bits 7 and 6 read as zero
// RL4 - first port bit 3 never drives, whatever its direction bit
// RL5 - pins in alternate function read as zero
// RL6 - bits 0,1,3,4 share group pull-up and group wake-on-change
// RL7 - as master clear input, bit 3 has pull-up on and no wake
// RL8 - second port bits 7 and 6 read as zero
// RL9 - direction-load instruction copies working register into that port's direction
// RL10 - direction one tristates the pin, zero drives the latch bit
// RL11 - timer clock source selection overrides the timer pin's direction
// RL12 - direction registers are write-only
// RL13 - outside circuitry holds input levels until the program reads them
// RL14 - output latches keep their value until rewritten
// RL15 - each pin except the input-only one has its own direction bit
// RL16 - a port write loads the output latches
// RL17 - wake flag set on pin-change wake reset, cleared by other resets
// RL18 - bit set or clear reads pins, modifies, writes all latches
// RL19 - group pull-up and wake enables are active-low option bits
// RL20 - wake on mismatch with level captured at last read while asleep
module bio_port_top
(
  clk,
  arst_n,
  fileAddr,
  fileWe,
  fileWdata,
  fileRe,
  fileRdata,
  bitOpEn,
  bitOpSet,
  bitOpIdx,
  dirLoad,
  dirSel,
  workReg,
  optionWe,
  optionWdata,
  masterClearCfg,
  altFuncFirst,
  altFuncSecond,
  sleeping,
  resetCauseValid,
  resetCauseWake,
  firstPinIn,
  secondPinIn,
  firstPinOut,
  firstPinOe,
  secondPinOut,
  secondPinOe,
  pullupOn,
  wakeEvent,
  pinWakeFlag
);
  input wire clk;
  input wire arst_n;
  input wire [4:0] fileAddr;
  input wire fileWe;
  input wire [7:0] fileWdata;
  input wire fileRe;
  output reg [7:0] fileRdata;
  input wire bitOpEn;
  input wire bitOpSet;
  input wire [2:0] bitOpIdx;
  input wire dirLoad;
  input wire [2:0] dirSel;
  input wire [7:0] workReg;
  input wire optionWe;
  input wire [7:0] optionWdata;
  input wire masterClearCfg;
  input wire [5:0] altFuncFirst;
  input wire [5:0] altFuncSecond;
  input wire sleeping;
  input wire resetCauseValid;
  input wire resetCauseWake;
  input wire [5:0] firstPinIn;
  input wire [5:0] secondPinIn;
  output wire [5:0] firstPinOut;
  output wire [5:0] firstPinOe;
  output wire [5:0] secondPinOut;
  output wire [5:0] secondPinOe;
  output reg [5:0] pullupOn;
  output reg wakeEvent;
  output reg pinWakeFlag;

  // ************************************************************
  // option bits and derived group controls
  // ************************************************************
  reg [7:0] option_q;
  wire pullupGroupEn;
  wire wakeGroupEn;
  wire tmrFromPin;
  wire [5:0] wakeMask;
  wire [5:0] forceFirst;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      option_q <= `BIO_OPT_RST;
    else if (optionWe)
      option_q <= optionWdata;
  end

  assign pullupGroupEn = ~option_q[`BIO_OPT_PULLUP_N_BIT]; // [RL19]
  assign wakeGroupEn = ~option_q[`BIO_OPT_WAKE_N_BIT]; // [RL19]
  assign tmrFromPin = option_q[`BIO_OPT_TMRSRC_BIT];
  // master clear pin drops out of the wake group
  assign wakeMask = masterClearCfg ? (`BIO_GROUP_MASK & ~(6'h01 << `BIO_INONLY_BIT)) : `BIO_GROUP_MASK; // [RL7]
  // input-only bit and, when counting external edges, the timer pin
  assign forceFirst = (6'h01 << `BIO_INONLY_BIT) | ({5'h00, tmrFromPin} << `BIO_TMRCLK_BIT); // [RL4] [RL11]

  // ************************************************************
  // file register writes and bit operations
  // ************************************************************
  wire [7:0] firstRead;
  wire [7:0] secondRead;
  wire bitOpFirst;
  wire bitOpSecond;
  wire [7:0] bitMask;
  wire [7:0] rmwFirst;
  wire [7:0] rmwSecond;
  wire firstLatchWe;
  wire secondLatchWe;
  wire [5:0] firstLatchData;
  wire [5:0] secondLatchData;

  assign bitOpFirst = bitOpEn && (fileAddr == `BIO_ADDR_FIRST);
  assign bitOpSecond = bitOpEn && (fileAddr == `BIO_ADDR_SECOND);
  assign bitMask = 8'h01 << bitOpIdx;
  // read from pins, so an input pin's level lands in its latch
  assign rmwFirst = bitOpSet ? (firstRead | bitMask) : (firstRead & ~bitMask); // [RL18]
  assign rmwSecond = bitOpSet ? (secondRead | bitMask) : (secondRead & ~bitMask); // [RL18]
  assign firstLatchWe = (fileWe && (fileAddr == `BIO_ADDR_FIRST)) || bitOpFirst; // [RL16]
  assign secondLatchWe = (fileWe && (fileAddr == `BIO_ADDR_SECOND)) || bitOpSecond; // [RL16]
  assign firstLatchData = bitOpFirst ? rmwFirst[5:0] : fileWdata[5:0];
  assign secondLatchData = bitOpSecond ? rmwSecond[5:0] : fileWdata[5:0];

  // ************************************************************
  // port banks
  // ************************************************************
  bio_port_bank uFirst
  (
    .clk(clk),
    .arst_n(arst_n),
    .latchWe(firstLatchWe),
    .latchWdata(firstLatchData),
    .dirWe(dirLoad && (dirSel == `BIO_DIR_SEL_FIRST)), // [RL9]
    .dirWdata(workReg[5:0]),
    .forceInMask(forceFirst),
    .altFuncMask(altFuncFirst),
    .pinIn(firstPinIn),
    .readData(firstRead),
    .pinOut(firstPinOut),
    .pinOe(firstPinOe)
  );

  bio_port_bank uSecond
  (
    .clk(clk),
    .arst_n(arst_n),
    .latchWe(secondLatchWe),
    .latchWdata(secondLatchData),
    .dirWe(dirLoad && (dirSel == `BIO_DIR_SEL_SECOND)), // [RL9]
    .dirWdata(workReg[5:0]),
    .forceInMask(6'h00),
    .altFuncMask(altFuncSecond),
    .pinIn(secondPinIn),
    .readData(secondRead),
    .pinOut(secondPinOut),
    .pinOe(secondPinOe)
  );

  // ************************************************************
  // read data, pull-ups, wake-on-change
  // ************************************************************
  reg [5:0] snapshot_q;
  reg [5:0] snapshot_d;
  reg [7:0] fileRdata_d;
  reg [5:0] pullupOn_d;
  reg [5:0] pinDiff;
  reg wakeEvent_d;
  reg pinWakeFlag_d;
  wire firstReadHit;
  wire [5:0] mclrBit;

  assign firstReadHit = fileRe && (fileAddr == `BIO_ADDR_FIRST);
  assign mclrBit = 6'h01 << `BIO_INONLY_BIT;

  // ************************************************************
  // read path
  // ************************************************************
  // every address answers each cycle; unmapped ones give zero
  always @*
  begin
    case (fileAddr)
      `BIO_ADDR_FIRST:
        fileRdata_d = firstRead; // [RL1] [RL3]
      `BIO_ADDR_SECOND:
        fileRdata_d = secondRead; // [RL8]
      `BIO_ADDR_STATUS:
      begin
        fileRdata_d = `BIO_RDATA_RST;
        fileRdata_d[`BIO_STATUS_WAKE_BIT] = pinWakeFlag; // [RL17]
      end
      default:
        fileRdata_d = `BIO_RDATA_RST;
    endcase
  end

  // one stage only: the core takes read data the cycle after it sets the address
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fileRdata <= `BIO_RDATA_RST;
    end
    else
    begin
      fileRdata <= fileRdata_d;
    end
  end

  // ************************************************************
  // weak pull-ups
  // ************************************************************
  always @*
  begin
    pullupOn_d = `BIO_PINS_RST;
    if (pullupGroupEn)
      pullupOn_d = `BIO_GROUP_MASK; // [RL6] [RL19]
    // master clear keeps its pull-up regardless of the group bit
    if (masterClearCfg)
      pullupOn_d = pullupOn_d | mclrBit; // [RL7]
  end

  // enables go out even for driving pins; the pad ignores a pull-up against its own driver
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pullupOn <= `BIO_PINS_RST;
    end
    else
    begin
      pullupOn <= pullupOn_d;
    end
  end

  // ************************************************************
  // wake-on-change
  // ************************************************************
  // raw pins, not masked by alternate function, so the compare stays honest
  always @*
  begin
    snapshot_d = snapshot_q;
    if (firstReadHit)
      snapshot_d = firstPinIn; // [RL20]
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      snapshot_q <= `BIO_PINS_RST;
    end
    else
    begin
      snapshot_q <= snapshot_d;
    end
  end

  // a level compare, not an edge: the event stands while any grouped pin differs
  always @*
  begin
    pinDiff = (firstPinIn ^ snapshot_q) & wakeMask; // [RL6] [RL7]
    wakeEvent_d = 1'b0;
    if (sleeping && wakeGroupEn && (pinDiff != 6'h00))
      wakeEvent_d = 1'b1; // [RL20]
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wakeEvent <= `BIO_FLAG_RST;
    end
    else
    begin
      wakeEvent <= wakeEvent_d;
    end
  end

  // ************************************************************
  // status wake flag
  // ************************************************************
  // reset cause is reported by the core once the reset sequence ends
  always @*
  begin
    pinWakeFlag_d = pinWakeFlag;
    if (resetCauseValid)
      pinWakeFlag_d = resetCauseWake; // [RL17]
  end

  // a hard reset clears it too, so only a reported wake cause leaves it set
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinWakeFlag <= `BIO_FLAG_RST;
    end
    else
    begin
      pinWakeFlag <= pinWakeFlag_d;
    end
  end
endmodule
